/* inc/eprom_prog_cfg.svh */
// Timing and geometry constants for the EPROM programming controller
`ifndef EPROM_PROG_CFG_SVH
`define EPROM_PROG_CFG_SVH
`define CLK_FREQ_HZ 50000000
`define ADDR_W 13
`define DATA_W 8
`define WORD_COUNT 8192
// Setup of address and data before a pulse, ns
`define SETUP_NS 2000
// Nominal program pulse width, us
`define PULSE_US 2000
// Output enable to valid data, ns (least settle before sampling)
`define READ_SETTLE_NS 450
// Output disable to data drive, ns
`define DISABLE_NS 2000
// Cumulative time per word, us
`define CUM_MIN_US 12000
`define CUM_MAX_US 50000
`define CYC_NS 20
`define SETUP_CYC ((`SETUP_NS + `CYC_NS - 1) / `CYC_NS)
`define PULSE_CYC ((`PULSE_US * 1000) / `CYC_NS)
`define READ_CYC ((`READ_SETTLE_NS + `CYC_NS - 1) / `CYC_NS)
`define DISABLE_CYC ((`DISABLE_NS + `CYC_NS - 1) / `CYC_NS)
`define MIN_BLOCKS (`CUM_MIN_US / `PULSE_US)
`define MAX_BLOCKS (`CUM_MAX_US / `PULSE_US)
// Address and image register stages ahead of the pins
`define PIPE_CYC 2
// Latency of the two-stage data synchroniser
`define SYNC_CYC 2
`endif

/* inc/eprom_prog_pkg.sv */
// Types shared by the EPROM programming controller
package eprom_prog_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DIS = 3'h1,
    ST_SETUP = 3'h3,
    ST_PULSE = 3'h2,
    ST_HOLD = 3'h6,
    ST_READ = 3'h7,
    ST_CHECK = 3'h5,
    ST_DONE = 3'h4
  } prog_state_e;
  typedef struct packed {
    logic busy;
    logic done;
    logic fail;
    logic verify_ok;
  } prog_status_s;
endpackage

/* rtl/image_ram.sv */
// Image memory holding the words to be programmed
`timescale 1ns/1ns
`default_nettype none
module image_ram #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input wire logic i_core_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  if (AW < 1 || DW < 1) begin : g_bad_params
    $error("image_ram: bad parameters");
  end
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge i_core_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

/* rtl/eprom_programmer.sv */
// Block-mode programming controller driving one or more UV EPROMs
`timescale 1ns/1ns
`default_nettype none
`include "eprom_prog_cfg.svh"
// Notes on behaviour
// - Program and read select a word with the same address decode.
// - Address and data are set up before each high-voltage pulse.
// - Each pulse is nominally 2 ms, within 1.9 to 2.1 ms.
// - One block pulses every one of 8192 addresses in order.
// - Cumulative time per word lies between 12 ms and 50 ms.
// - Only chips meant to take the word get the pulse.
// - At most one chip has its output enable low at a time.
module eprom_programmer
  import eprom_prog_pkg::*;
#(
  parameter int CHIPS = 1,
  parameter int PULSE_CYC = `PULSE_CYC,
  parameter int WORDS = `WORD_COUNT
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_load_we,
  input wire logic [`ADDR_W-1:0] i_load_addr,
  input wire logic [`DATA_W-1:0] i_load_data,
  input wire logic [CHIPS-1:0] i_chip_sel,
  input wire logic i_start,
  input wire logic [`DATA_W-1:0] i_dq_in,
  output logic [`ADDR_W-1:0] o_addr,
  output logic [`DATA_W-1:0] o_dq_out,
  output logic o_dq_oe_n,
  output logic [CHIPS-1:0] o_oe_n,
  output logic [CHIPS-1:0] o_prog_pulse,
  output var prog_status_s o_status
);
  localparam bit PARAMS_OK = CHIPS >= 1 && WORDS >= 1 &&
    WORDS <= `WORD_COUNT && PULSE_CYC >= 1;
  if (!PARAMS_OK) begin : g_bad_params
    $error("eprom_programmer: bad parameters");
  end
  // Counter spans the pulse and every gap that is loaded into it
  localparam int CNT_SPAN = PULSE_CYC + `DISABLE_CYC + `SETUP_CYC +
    `PIPE_CYC + `READ_CYC + `SYNC_CYC;
  localparam int CW = $clog2(CNT_SPAN + 1) + 1;
  localparam int BW = $clog2(`MAX_BLOCKS + 1);
  localparam int CIW = (CHIPS > 1) ? $clog2(CHIPS) : 1;

  // ========================================
  // Pin synchroniser
  logic [`DATA_W-1:0] dq_s1;
  logic [`DATA_W-1:0] dq_s2;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else if (i_ce) begin
      dq_s1 <= i_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // ========================================
  // Sequencer state
  prog_state_e state;
  logic [CW-1:0] cnt;
  logic [`ADDR_W-1:0] addr;
  logic [BW-1:0] blocks;
  logic [CIW-1:0] chip;
  logic mismatch;
  logic [`DATA_W-1:0] image;
  logic last_addr;
  logic last_chip;
  assign last_addr = (addr == `ADDR_W'(WORDS - 1));
  assign last_chip = (chip == CIW'(CHIPS - 1));

  image_ram #(.AW(`ADDR_W), .DW(`DATA_W)) u_image (
    .i_core_clk(i_core_clk),
    .i_ce(i_ce),
    .i_we(i_load_we && !o_status.busy),
    .i_waddr(i_load_addr),
    .i_wdata(i_load_data),
    .i_raddr(addr),
    .o_rdata(image)
  );

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      addr <= '0;
      blocks <= '0;
      chip <= '0;
      mismatch <= 1'b0;
    end else if (i_ce) begin
      unique case (state)
        ST_IDLE: begin
          if (i_start) begin
            state <= ST_DIS;
            addr <= '0;
            blocks <= '0;
            chip <= '0;
            mismatch <= 1'b0;
            cnt <= CW'(`DISABLE_CYC);
          end
        end
        ST_DIS: begin
          if (cnt == '0) begin
            state <= ST_SETUP;
            cnt <= CW'(`SETUP_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_SETUP: begin
          if (cnt == '0) begin
            state <= ST_PULSE;
            cnt <= CW'(PULSE_CYC - 1);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_PULSE: begin
          if (cnt == '0) begin
            state <= ST_HOLD;
            cnt <= CW'(`SETUP_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_HOLD: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (last_addr) begin
            addr <= '0;
            blocks <= blocks + 1'b1;
            chip <= '0;
            mismatch <= 1'b0;
            state <= ST_READ;
            cnt <= CW'(`READ_CYC + `SYNC_CYC);
          end else begin
            addr <= addr + 1'b1;
            state <= ST_SETUP;
            // New address reaches the pins one cycle late, its data two cycles late
            cnt <= CW'(`SETUP_CYC + `PIPE_CYC);
          end
        end
        ST_READ: begin
          if (cnt == '0) begin
            state <= ST_CHECK;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_CHECK: begin
          if (dq_s2 != (i_chip_sel[chip] ? image : {`DATA_W{1'b1}})) begin
            mismatch <= 1'b1;
          end
          cnt <= CW'(`READ_CYC + `SYNC_CYC);
          if (!last_chip) begin
            chip <= chip + 1'b1;
            state <= ST_READ;
          end else if (!last_addr) begin
            chip <= '0;
            addr <= addr + 1'b1;
            state <= ST_READ;
          end else begin
            // minimum total, then stop on match or limit
            if (blocks >= BW'(`MIN_BLOCKS) &&
                (!(mismatch || dq_s2 != (i_chip_sel[chip] ? image :
                 {`DATA_W{1'b1}})) || blocks >= BW'(`MAX_BLOCKS))) begin
              state <= ST_DONE;
            end else begin
              state <= ST_DIS;
              addr <= '0;
              chip <= '0;
              cnt <= CW'(`DISABLE_CYC);
            end
            mismatch <= mismatch ||
              (dq_s2 != (i_chip_sel[chip] ? image : {`DATA_W{1'b1}}));
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================
  // Pin drive
  logic pgm_phase;
  logic read_phase;
  assign pgm_phase = (state == ST_SETUP) || (state == ST_PULSE) ||
                     (state == ST_HOLD);
  assign read_phase = (state == ST_READ) || (state == ST_CHECK);
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_addr <= '0;
      o_dq_out <= '0;
    end else if (i_ce) begin
      o_addr <= addr;
      o_dq_out <= image;
    end
  end
  // Data lines driven only while no chip outputs are enabled
  assign o_dq_oe_n = !pgm_phase;
  genvar g;
  generate
    for (g = 0; g < CHIPS; g++) begin : g_chip
      // one output enable low, only while reading
      assign o_oe_n[g] = !(read_phase && chip == CIW'(g));
      // pulse only chips selected to take the image
      assign o_prog_pulse[g] = (state == ST_PULSE) && i_chip_sel[g];
    end
  endgenerate

  // ========================================
  // Status
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_status <= '0;
    end else if (i_ce) begin
      o_status.busy <= (state != ST_IDLE) || i_start;
      o_status.done <= (state == ST_DONE);
      if (state == ST_DONE) begin
        o_status.verify_ok <= !mismatch; // no repair of stuck zeros
        o_status.fail <= mismatch;
      end
    end
  end

  // ========================================
  // Checks
  a_pulse_no_read: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) |o_prog_pulse |-> &o_oe_n)
    else $error("output enable low during pulse");
  a_one_enable: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) $onehot0(~o_oe_n))
    else $error("two chips enabled");
  a_setup_before: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) $rose(|o_prog_pulse) |->
    $past(state == ST_SETUP))
    else $error("pulse without setup");
  a_pulse_unsel: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) (o_prog_pulse & ~i_chip_sel) == '0)
    else $error("pulse on unselected chip");
  a_addr_stable: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) i_ce && state == ST_PULSE && $past(i_ce) &&
    $past(state) == ST_PULSE |-> $stable(o_addr))
    else $error("address moved during pulse");
  a_pulse_ends: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) i_ce && state == ST_PULSE && cnt == '0
    |=> state == ST_HOLD)
    else $error("pulse too long");
  a_dq_not_read: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) !o_dq_oe_n |-> &o_oe_n)
    else $error("bus contention");
  a_block_wrap: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) i_ce && state == ST_HOLD && cnt == '0 &&
    last_addr |=> state == ST_READ && addr == '0)
    else $error("block did not wrap");
  a_min_blocks: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) state == ST_DONE |->
    blocks >= BW'(`MIN_BLOCKS))
    else $error("too few blocks");
  a_max_blocks: assert property (@(posedge i_core_clk)
    disable iff (!i_resetn) blocks <= BW'(`MAX_BLOCKS))
    else $error("too many blocks");
  c_pulse: cover property (@(posedge i_core_clk) $rose(|o_prog_pulse));
  c_verify: cover property (@(posedge i_core_clk) state == ST_CHECK);
  c_done_ok: cover property (@(posedge i_core_clk)
    o_status.done && o_status.verify_ok);
endmodule
`default_nettype wire

/* verification/eprom_model.sv */
// Behavioural UV EPROM standing on the far side of the programmer
`timescale 1ns/1ns
`default_nettype none
module eprom_model #(
  parameter int WORDS = 4
) (
  input wire logic i_core_clk,
  input wire logic [12:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_oe_n,
  input wire logic i_prog,
  output logic [7:0] o_dq,
  output logic o_drive
);
  // ========================================
  // Array
  logic [7:0] mem [WORDS];
  int idx;
  assign idx = int'(i_addr) % WORDS;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // A pulse can only clear bits
  always @(posedge i_core_clk) begin
    if (i_prog) mem[idx] <= mem[idx] & i_dq;
  end
  assign o_drive = !i_oe_n && !i_prog;
  assign o_dq = mem[idx];
endmodule
`default_nettype wire

/* verification/test_eprom_programmer.sv */
// Self-checking bench for the EPROM programmer with two chips
`timescale 1ns/1ns
`default_nettype none
module test_eprom_programmer
  import eprom_prog_pkg::*;
;
  localparam int W = 4;
  localparam int P = 4;
  logic i_core_clk = 1'b0;
  logic i_resetn, i_ce, i_load_we, i_start;
  logic [12:0] i_load_addr, o_addr;
  logic [7:0] i_load_data, o_dq_out, dq, last;
  logic [1:0] i_chip_sel, o_oe_n, o_prog_pulse, drv;
  logic o_dq_oe_n;
  logic [7:0] m_dq [2];
  prog_status_s o_status;
  int error_cnt = 0;
  int checked = 0;
  int wid [2] = '{0, 0};
  int pulses [2] = '{0, 0};
  // Data setup before a pulse: 2 us at 20 ns
  localparam int SU = 100;
  int stb = 0;
  logic [12:0] p_addr;
  logic [7:0] p_dq;
  logic [7:0] img_a [W] = '{8'h5A, 8'h00, 8'hFF, 8'hC3};
  logic [7:0] img_f [W] = '{default: 8'hFF};

  always #10 i_core_clk = ~i_core_clk;

  eprom_programmer #(.CHIPS(2), .PULSE_CYC(P), .WORDS(W)) DUT (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_load_we(i_load_we), .i_load_addr(i_load_addr),
    .i_load_data(i_load_data), .i_chip_sel(i_chip_sel),
    .i_start(i_start), .i_dq_in(dq), .o_addr(o_addr),
    .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n), .o_oe_n(o_oe_n),
    .o_prog_pulse(o_prog_pulse), .o_status(o_status));
  eprom_model #(.WORDS(W)) u_m0 (.i_core_clk(i_core_clk),
    .i_addr(o_addr), .i_dq(dq), .i_oe_n(o_oe_n[0]),
    .i_prog(o_prog_pulse[0]), .o_dq(m_dq[0]), .o_drive(drv[0]));
  eprom_model #(.WORDS(W)) u_m1 (.i_core_clk(i_core_clk),
    .i_addr(o_addr), .i_dq(dq), .i_oe_n(o_oe_n[1]),
    .i_prog(o_prog_pulse[1]), .o_dq(m_dq[1]), .o_drive(drv[1]));
  // Undriven bus shows the inverse of its last level
  assign dq = !o_dq_oe_n ? o_dq_out : drv[0] ? m_dq[0] :
              drv[1] ? m_dq[1] : ~last;

  // ========================================
  // Checking helpers and pin monitor
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
      error_cnt++;
    end
  endtask

  // Pins are judged on the falling edge, where they have settled
  always @(negedge i_core_clk) begin
    last <= dq;
    if (o_dq_oe_n !== 1'b0 || o_addr !== p_addr || o_dq_out !== p_dq) begin
      stb = 0;
    end else begin
      stb++;
    end
    p_addr = o_addr;
    p_dq = o_dq_out;
    if (o_prog_pulse !== 2'b00 && wid[0] == 0 && wid[1] == 0) begin
      chk("setup cycles", SU, (stb >= SU) ? SU : stb);
    end
    for (int c = 0; c < 2; c++) begin
      if (o_prog_pulse[c] === 1'b1) wid[c]++;
      else if (wid[c] != 0) begin
        chk("pulse width", P, wid[c]);
        pulses[c]++;
        wid[c] = 0;
      end
    end
    if (o_prog_pulse !== 2'b00) chk("data drive", 0, o_dq_oe_n);
    if (o_oe_n === 2'b00) chk("single enable", 1, 0);
  end

  task automatic load(input logic [7:0] img [W]);
    for (int i = 0; i < W; i++) begin
      i_load_we = 1'b1;
      i_load_addr = 13'(i);
      i_load_data = img[i];
      @(posedge i_core_clk) #2;
    end
    i_load_we = 1'b0;
  endtask

  task automatic run(input logic [1:0] sel, input int lim);
    int n;
    pulses = '{0, 0};
    i_chip_sel = sel;
    i_start = 1'b1;
    @(posedge i_core_clk) #2;
    i_start = 1'b0;
    repeat (50) @(posedge i_core_clk);
    #2 i_start = 1'b1;
    @(posedge i_core_clk) #2;
    i_start = 1'b0;
    // Freeze across the end of the disable gap: drive must not start
    repeat (43) @(posedge i_core_clk);
    #2 i_ce = 1'b0;
    repeat (20) @(posedge i_core_clk);
    #2 chk("frozen drive", 1, o_dq_oe_n);
    i_ce = 1'b1;
    n = 0;
    while (o_status.done !== 1'b1 && n < lim) begin
      @(posedge i_core_clk) #1;
      n++;
    end
    if (n >= lim) chk("done seen", 1, 0);
    @(posedge i_core_clk) #2;
  endtask

  // ========================================
  // Scenarios
  task automatic test_program_select;
    load(img_a);
    run(2'b01, 20000);
    chk("verify ok", 1, o_status.verify_ok);
    chk("fail", 0, o_status.fail);
    chk("pulses chip0", 6 * W, pulses[0]);
    chk("pulses chip1", 0, pulses[1]);
    for (int i = 0; i < W; i++) begin
      chk("chip0 word", img_a[i], u_m0.mem[i]);
      chk("chip1 word", 8'hFF, u_m1.mem[i]);
    end
    $display("test_program_select finished");
  endtask

  task automatic test_no_unprogram;
    load(img_f);
    run(2'b11, 40000);
    chk("fail", 1, o_status.fail);
    chk("verify ok", 0, o_status.verify_ok);
    chk("pulses chip0", 25 * W, pulses[0]);
    chk("pulses chip1", 25 * W, pulses[1]);
    for (int i = 0; i < W; i++) begin
      chk("chip0 kept", img_a[i], u_m0.mem[i]);
    end
    $display("test_no_unprogram finished");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_load_we = 1'b0;
    i_load_addr = 13'h0000;
    i_load_data = 8'h00;
    i_chip_sel = 2'b00;
    i_start = 1'b0;
    repeat (16) @(posedge i_core_clk);
    #2 i_resetn = 1'b1;
    @(posedge i_core_clk) #2;
    test_program_select;
    test_no_unprogram;
    test_done;
  end

  initial begin
    #1600000;
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
